// ### rtcs_pkg.sv
// shared constants and types for the rtc serial slave
package rtcs_pkg;
   localparam logic [7:0] ADDR_WR = 8'ha2;
   localparam logic [7:0] ADDR_RD = 8'ha3;
   localparam int PTR_W = 4;
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] PTR_RST = 4'h0;
   localparam logic [3:0] PTR_STEP = 4'h1;
   localparam int WDOG_TIME_S = 1;
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int WDOG_CYCLES = WDOG_TIME_S * CLK_FREQ_HZ;
   localparam int WDOG_CW = 28;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_RX_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_TX_ACK = 3'b110,
      ST_WAIT = 3'b111
   } rtcs_state_e;
endpackage : rtcs_pkg

// ### rtcs_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module rtcs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } rtcs_sync_s;

   rtcs_sync_s r;
   rtcs_sync_s n;

   // meta feeds only the second stage
   always_comb begin
      n.meta = d;
      n.held = r.meta;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.held;
endmodule : rtcs_sync

// ### rtcs_wdog.sv
// interface timeout guard on the system clock
`timescale 1ns/1ps
module rtcs_wdog #(
   parameter int WDOG_CYCLES = rtcs_pkg::WDOG_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic go_tgl,
   input wire logic freeze_s,
   output logic trip_tgl,
   output logic lost_sec
);
   import rtcs_pkg::*;

   localparam logic [WDOG_CW-1:0] CNT_LAST = WDOG_CW'(WDOG_CYCLES - 1);

   typedef struct packed {
      logic run;
      logic [WDOG_CW-1:0] cnt;
      logic go_p;
      logic frz_p;
      logic trip;
      logic lost;
   } rtcs_wdog_s;

   rtcs_wdog_s r;
   rtcs_wdog_s n;
   logic go_s;
   logic go_e;

   rtcs_sync #(.W(1)) u_go (
      .clk(clk),
      .nrst(nrst),
      .d(go_tgl),
      .q(go_s)
   );

   assign go_e = go_s ^ r.go_p;

   always_comb begin
      n = r;
      n.go_p = go_s;
      n.frz_p = freeze_s;
      n.lost = 1'b0;
      if (go_e) begin
         n.run = 1'b1;
         n.cnt = '0;
      end else if (r.run && r.frz_p && !freeze_s) begin
         n.run = 1'b0;
      end else if (r.run) begin
         if (r.cnt == CNT_LAST) begin
            n.run = 1'b0;
            n.trip = ~r.trip;
            n.lost = 1'b1;
         end else begin
            n.cnt = r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign trip_tgl = r.trip;
   assign lost_sec = r.lost;

   lost_pulse_a: assert property (@(posedge clk) disable iff (!nrst) lost_sec |=> !lost_sec)
      else $error("lost second pulse longer than one cycle");
   trip_time_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(r.lost) |-> !r.run && $past(r.run) && ($past(r.cnt) == CNT_LAST))
      else $error("guard tripped at the wrong count");
endmodule : rtcs_wdog

// ### rtcs_slave.sv
// two-wire serial slave with register pointer and timeout guard
`timescale 1ns/1ps
// Contract
// - data held steady while clock high; changes then are control events; guard expiry releases data at any clock level
// - data falling with clock high is start; begin taking address
// - data rising with clock high is stop; end transfer and release
// - any number of eight-bit bytes, each followed by one acknowledge clock
// - as receiver, acknowledge every byte taken in
// - acknowledger holds data low across the acknowledge clock high phase
// - master withholds final acknowledge; device then releases data high
// - first byte after start is the address; answer only when selected
// - slave only; clock is input, data line is two-way
// - answer a3 as read address and a2 as write address
// - register pointer four bits; upper four bits of pointer byte ignored
// - time counting frozen while an access is in progress
// - access longer than one second is cleared and counting resumes
// - guard trips between one and two seconds after a valid address
// - every guard expiry drops exactly one second of kept time
// - reset clears interface and pointer; no bus traffic meanwhile
module rtcs_slave #(
   parameter int WDOG_CYCLES = rtcs_pkg::WDOG_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic [rtcs_pkg::PTR_W-1:0] reg_addr,
   input wire logic [rtcs_pkg::BYTE_W-1:0] rd_data,
   output logic rd_en,
   output logic wr_en,
   output logic [rtcs_pkg::PTR_W-1:0] wr_addr,
   output logic [rtcs_pkg::BYTE_W-1:0] wr_data,
   output logic freeze,
   output logic lost_sec
);
   import rtcs_pkg::*;

   typedef struct packed {
      rtcs_state_e st;
      logic [2:0] cnt;
      logic [BYTE_W-1:0] sr;
      logic rw;
      logic ack_on;
      logic more;
      logic first;
      logic [PTR_W-1:0] ptr;
      logic active;
      logic go;
      logic trip_p;
      logic scl_p;
      logic sda_p;
      logic sda_o;
      logic sda_oe;
      logic rd_en;
      logic wr_en;
      logic [PTR_W-1:0] wr_addr;
      logic [BYTE_W-1:0] wr_data;
   } rtcs_link_s;

   rtcs_link_s r;
   rtcs_link_s n;
   logic [1:0] pin_s;
   logic scl_s;
   logic sda_s;
   logic trip_tgl;
   logic trip_s;
   logic rise_c;
   logic fall_c;
   logic start_c;
   logic stop_c;
   logic trip_hit;
   logic quiet;
   logic oe_ev;
   logic [BYTE_W-1:0] byte_in;

   // both the write and the read address share the upper seven bits
   function automatic logic addr_hit(input logic [BYTE_W-1:0] b);
      return b[7:1] == ADDR_WR[7:1];
   endfunction : addr_hit

   function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
      return p + PTR_STEP;
   endfunction : ptr_next

   // drive msb of a fresh byte and step the pointer past it
   function automatic rtcs_link_s tx_load(input rtcs_link_s s, input logic [BYTE_W-1:0] d);
      rtcs_link_s t;
      t = s;
      t.st = ST_TX;
      t.sr = d;
      t.sda_oe = ~d[7];
      t.cnt = 3'h0;
      t.rd_en = 1'b1;
      t.ptr = ptr_next(s.ptr);
      return t;
   endfunction : tx_load

   // bus pins are asynchronous to the link clock
   rtcs_sync #(.W(2)) u_pin (
      .clk(link_clk),
      .nrst(nrst),
      .d({scl_i, sda_i}),
      .q(pin_s)
   );

   rtcs_sync #(.W(1)) u_trip (
      .clk(link_clk),
      .nrst(nrst),
      .d(trip_tgl),
      .q(trip_s)
   );

   rtcs_sync #(.W(1)) u_frz (
      .clk(clk),
      .nrst(nrst),
      .d(r.active),
      .q(freeze)
   );

   rtcs_wdog #(.WDOG_CYCLES(WDOG_CYCLES)) u_wdog (
      .clk(clk),
      .nrst(nrst),
      .go_tgl(r.go),
      .freeze_s(freeze),
      .trip_tgl(trip_tgl),
      .lost_sec(lost_sec)
   );

   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];
   assign rise_c = scl_s && !r.scl_p;
   assign fall_c = !scl_s && r.scl_p;
   assign start_c = scl_s && r.scl_p && r.sda_p && !sda_s;
   assign stop_c = scl_s && r.scl_p && !r.sda_p && sda_s;
   assign trip_hit = trip_s ^ r.trip_p;
   assign quiet = !start_c && !stop_c && !trip_hit;
   assign oe_ev = fall_c || start_c || stop_c || trip_hit;
   assign byte_in = {r.sr[6:0], sda_s};

   always_comb begin
      n = r;
      n.scl_p = scl_s;
      n.sda_p = sda_s;
      n.trip_p = trip_s;
      n.rd_en = 1'b0;
      n.wr_en = 1'b0;
      if (trip_hit || stop_c) begin
         n.st = ST_IDLE;
         n.sda_oe = 1'b0;
         n.ack_on = 1'b0;
         n.active = 1'b0;
      end else if (start_c) begin
         n.st = ST_ADDR;
         n.cnt = 3'h0;
         n.sda_oe = 1'b0;
         n.ack_on = 1'b0;
      end else begin
         unique case (r.st)
            ST_IDLE, ST_WAIT: begin
            end
            ST_ADDR: begin
               if (rise_c) begin
                  n.sr = byte_in;
                  n.cnt = r.cnt + 3'h1;
                  if (r.cnt == BIT_LAST) begin
                     if (addr_hit(byte_in)) begin
                        n.st = ST_ADDR_ACK;
                        n.rw = byte_in[0];
                        n.first = 1'b1;
                        n.active = 1'b1;
                        // guard counts from the first address of a burst only
                        n.go = r.active ? r.go : ~r.go;
                     end else begin
                        n.st = ST_IDLE;
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (fall_c && !r.ack_on) begin
                  n.sda_oe = 1'b1;
                  n.ack_on = 1'b1;
               end else if (fall_c) begin
                  n.ack_on = 1'b0;
                  if (r.rw) begin
                     n = tx_load(n, rd_data);
                  end else begin
                     n.st = ST_RX;
                     n.sda_oe = 1'b0;
                     n.cnt = 3'h0;
                  end
               end
            end
            ST_RX: begin
               if (rise_c) begin
                  n.sr = byte_in;
                  n.cnt = r.cnt + 3'h1;
                  if (r.cnt == BIT_LAST) begin
                     n.st = ST_RX_ACK;
                  end
               end
            end
            ST_RX_ACK: begin
               if (fall_c && !r.ack_on) begin
                  n.sda_oe = 1'b1;
                  n.ack_on = 1'b1;
                  if (r.first) begin
                     n.ptr = r.sr[PTR_W-1:0];
                     n.first = 1'b0;
                  end else begin
                     n.wr_en = 1'b1;
                     n.wr_addr = r.ptr;
                     n.wr_data = r.sr;
                     n.ptr = ptr_next(r.ptr);
                  end
               end else if (fall_c) begin
                  n.ack_on = 1'b0;
                  n.sda_oe = 1'b0;
                  n.st = ST_RX;
                  n.cnt = 3'h0;
               end
            end
            ST_TX: begin
               if (fall_c) begin
                  if (r.cnt == BIT_LAST) begin
                     n.sda_oe = 1'b0;
                     n.st = ST_TX_ACK;
                  end else begin
                     n.sr = {r.sr[6:0], 1'b0};
                     n.sda_oe = ~r.sr[6];
                     n.cnt = r.cnt + 3'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (rise_c) begin
                  n.more = !sda_s;
               end else if (fall_c) begin
                  if (r.more) begin
                     n = tx_load(n, rd_data);
                  end else begin
                     n.st = ST_WAIT;
                     n.sda_oe = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // async reset here acts as the internal reset of the interface
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // pin is open drain: only the enable ever changes
   assign sda_o = r.sda_o;
   assign sda_oe = r.sda_oe;
   assign reg_addr = r.ptr;
   assign rd_en = r.rd_en;
   assign wr_en = r.wr_en;
   assign wr_addr = r.wr_addr;
   assign wr_data = r.wr_data;

   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!nrst);

   sequence tx_nack;
      r.st == ST_TX_ACK && fall_c && !r.more && quiet;
   endsequence

   sequence let_go;
      r.st == ST_WAIT && !r.sda_oe;
   endsequence

   sequence ack_begin;
      r.st == ST_RX_ACK && fall_c && !r.ack_on && quiet;
   endsequence

   sequence ack_held;
      r.sda_oe && r.ack_on;
   endsequence

   start_seen_a: assert property (start_c && !stop_c && !trip_hit |=> r.st == ST_ADDR && !r.sda_oe)
      else $error("start not taken");
   stop_seen_a: assert property (stop_c |=> r.st == ST_IDLE && !r.active && !r.sda_oe)
      else $error("stop did not release the interface");
   oe_steady_a: assert property ($changed(r.sda_oe) |-> $past(oe_ev))
      else $error("data line moved while clock high");
   rx_ack_a: assert property (ack_begin |=> ack_held)
      else $error("received byte not acknowledged");
   ack_hold_a: assert property (r.ack_on && r.sda_oe && !fall_c && quiet |=> r.sda_oe)
      else $error("acknowledge dropped during clock high");
   addr_miss_a: assert property (
      r.st == ST_ADDR && rise_c && r.cnt == BIT_LAST && !addr_hit(byte_in) |=> r.st == ST_IDLE && !r.active)
      else $error("foreign address answered");
   addr_hit_a: assert property (
      r.st == ST_ADDR && rise_c && r.cnt == BIT_LAST && addr_hit(byte_in)
      |=> r.st == ST_ADDR_ACK && r.active && r.rw == $past(sda_s))
      else $error("own address not taken with its direction");
   ptr_load_a: assert property (
      ack_begin and r.first |=> ({4'h0, r.ptr} == ($past(r.sr) & 8'h0f)) && !r.wr_en)
      else $error("pointer byte not loaded from its low bits");
   wr_step_a: assert property (r.wr_en |-> r.ptr == ptr_next(r.wr_addr))
      else $error("pointer did not step after a write");
   rd_step_a: assert property (r.rd_en |-> r.ptr == ptr_next($past(r.ptr)) && r.st == ST_TX)
      else $error("pointer did not step after a read");
   nack_a: assert property (tx_nack |=> let_go)
      else $error("data line not released after missing acknowledge");
   trip_clear_a: assert property (trip_hit |=> r.st == ST_IDLE && !r.active && !r.sda_oe)
      else $error("guard expiry did not clear the interface");
   only_low_a: assert property (!r.sda_o)
      else $error("data line driven high");
endmodule : rtcs_slave

// ### rtcs_mm.sv
// two-wire bus master model: drives the bus clock and pulls data low
`timescale 1ns/1ps
module rtcs_mm #(
   parameter int HP = 120
) (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic pull
);
   // bus clock stands still high between frames
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // data moves a fifth into the low phase, clear of the falling clock
   task automatic bit_cyc(input logic low, output logic s);
      wt(HP / 4);
      pull = low;
      wt(HP);
      scl = 1'b1;
      wt(HP / 2);
      s = sda;
      wt(HP / 2);
      s = s | sda;
      scl = 1'b0;
   endtask : bit_cyc
   task automatic start_c;
      wt(HP / 4);
      pull = 1'b0;
      wt(HP);
      scl = 1'b1;
      wt(HP);
      pull = 1'b1;
      wt(HP);
      scl = 1'b0;
   endtask : start_c
   task automatic stop_c;
      wt(HP / 4);
      pull = 1'b1;
      wt(HP);
      scl = 1'b1;
      wt(HP);
      pull = 1'b0;
      wt(HP);
   endtask : stop_c
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(~b[i], s);
      end
      bit_cyc(1'b0, s);
      ack = ~s;
   endtask : put_byte
   task automatic get_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b0, s);
         b[i] = s;
      end
      bit_cyc(ack, s);
   endtask : get_byte
endmodule : rtcs_mm

// ### testbench.sv
// testbench for the rtc serial slave with its bus master model
`timescale 1ns/1ps
module testbench;
   import rtcs_pkg::*;
   // guard must outlast the longest access here, some 13k cycles
   localparam int GUARD_CYC = 16000;
   localparam int RUN_NS = 450_000;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, pull, sda, sda_o, sda_oe, rd_en, wr_en, freeze, lost_sec;
   logic [PTR_W-1:0] reg_addr, wr_addr;
   logic [BYTE_W-1:0] wr_data, rd_data;
   logic [BYTE_W-1:0] mem [16];
   logic [BYTE_W-1:0] em [16];
   int err_total = 0;
   int checked = 0;
   int n_lost = 0;
   int n_wr = 0;
   int n_rd = 0;
   always #2.5 clk = ~clk;
   initial #7 forever #24 link_clk = ~link_clk;
   // pull-up wins unless somebody pulls low
   assign sda = (pull === 1'b1 || (sda_oe === 1'b1 && sda_o === 1'b0)) ? 1'b0 : 1'b1;
   assign rd_data = mem[reg_addr];
   always @(posedge link_clk) if (wr_en === 1'b1) begin
      mem[wr_addr] <= wr_data;
      n_wr++;
   end
   always @(posedge link_clk) if (rd_en === 1'b1) n_rd++;
   always @(posedge clk) if (lost_sec === 1'b1) n_lost++;
   always @(sda_oe) if (nrst === 1'b1 && scl === 1'b1) begin
      err_total++;
      $display("BAD sda_oe edge expected scl 0 seen 1");
   end
   rtcs_mm rtcs_mm_inst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
   rtcs_slave #(.WDOG_CYCLES(GUARD_CYC)) rtcs_slave_inst (.clk(clk), .nrst(nrst), .link_clk(link_clk),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .reg_addr(reg_addr), .rd_data(rd_data),
      .rd_en(rd_en), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .freeze(freeze),
      .lost_sec(lost_sec));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   task automatic t_write;
      logic a;
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(ADDR_WR, a);
      chk("wr addr ack", 1, a);
      chk("freeze on", 1, freeze);
      rtcs_mm_inst.put_byte(8'hf5, a);
      chk("ptr ack", 1, a);
      chk("ptr", 5, reg_addr);
      rtcs_mm_inst.put_byte(8'h3c, a);
      rtcs_mm_inst.put_byte(8'h7e, a);
      chk("data ack", 1, a);
      rtcs_mm_inst.stop_c();
      em[5] = 8'h3c;
      em[6] = 8'h7e;
      chk("mem5", em[5], mem[5]);
      chk("mem6", em[6], mem[6]);
      chk("wr pulses", 2, n_wr);
      chk("freeze off", 0, freeze);
      $display("write test done");
   endtask : t_write
   task automatic t_read(input logic [3:0] p, input int n);
      logic a;
      logic [7:0] d;
      int r0;
      r0 = n_rd;
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(ADDR_WR, a);
      rtcs_mm_inst.put_byte({4'h0, p}, a);
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(ADDR_RD, a);
      chk("rd addr ack", 1, a);
      for (int i = 0; i < n; i++) begin
         rtcs_mm_inst.get_byte(i < n - 1, d);
         chk("rd data", em[p + i[3:0]], d);
      end
      chk("rd pulses", 8'(n), 8'(n_rd - r0));
      rtcs_mm_inst.wt(40);
      chk("released", 1, sda);
      rtcs_mm_inst.stop_c();
      $display("read test done");
   endtask : t_read
   task automatic t_other;
      logic a;
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(8'ha4, a);
      chk("foreign ack", 0, a);
      rtcs_mm_inst.put_byte(8'h00, a);
      chk("foreign data ack", 0, a);
      chk("no freeze", 0, freeze);
      rtcs_mm_inst.stop_c();
      $display("foreign test done");
   endtask : t_other
   // master stalls with the clock low while the slave drives a zero bit
   task automatic t_guard;
      logic a;
      int n;
      int l0;
      l0 = n_lost;
      n = 0;
      // msb zero so the slave holds the line when the master stalls
      mem[reg_addr] = 8'h3c;
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(ADDR_RD, a);
      rtcs_mm_inst.wt(60);
      chk("bus held", 1, sda_oe);
      chk("drive level", 0, sda_o);
      while (lost_sec !== 1'b1 && n < 2 * GUARD_CYC + 10) begin
         @(negedge clk);
         n++;
      end
      // ack clock and settle wait use some 420 guard cycles before n runs
      chk("trip late", 1, n <= 2 * GUARD_CYC);
      chk("trip early", 1, n >= GUARD_CYC - 500);
      rtcs_mm_inst.wt(60);
      chk("freeze cleared", 0, freeze);
      chk("bus released", 0, sda_oe);
      chk("seconds lost", 8'(l0 + 1), 8'(n_lost));
      rtcs_mm_inst.stop_c();
      $display("guard test done");
   endtask : t_guard
   task automatic t_reset;
      logic a;
      logic [7:0] d;
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(ADDR_WR, a);
      rtcs_mm_inst.put_byte(8'h09, a);
      chk("ptr before reset", 9, reg_addr);
      nrst = 1'b0;
      rtcs_mm_inst.wt(40);
      chk("reset ptr", PTR_RST, reg_addr);
      chk("reset oe", 0, sda_oe);
      chk("reset freeze", 0, freeze);
      rtcs_mm_inst.stop_c();
      nrst = 1'b1;
      rtcs_mm_inst.wt(60);
      rtcs_mm_inst.start_c();
      rtcs_mm_inst.put_byte(ADDR_RD, a);
      rtcs_mm_inst.get_byte(1'b0, d);
      chk("read after reset", em[0], d);
      rtcs_mm_inst.stop_c();
      $display("reset test done");
   endtask : t_reset
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 8'ha0 + 8'(i);
         em[i] = 8'ha0 + 8'(i);
      end
      // reset spans several edges of the slower link clock
      repeat (5) @(negedge link_clk);
      nrst = 1'b1;
      rtcs_mm_inst.wt(60);
      t_write();
      t_read(4'h5, 3);
      t_read(4'hf, 2);
      t_other();
      t_guard();
      t_reset();
      end_sim();
   end
   // some 90k clock cycles against an expected run of about 76k
   initial begin
      #RUN_NS;
      err_total++;
      $display("BAD run time expected done seen timeout");
      end_sim();
   end
endmodule : testbench
